// >>> include/mdso_pkg.sv
// Contract
// - chip select low only during datagram
// - sample reply input during each transfer
// - master generates serial clock output
// - low phase from bits 23:20
// - high phase from bits 27:24
// - block time 31:28 between datagrams
// - clock and select high when idle
// - zero timing value means two cycles
// - timing fields reach fifteen cycles
// - step moves counter, updates phase currents
// - current change triggers current datagram
// - current as magnitude plus polarity format
// - resolution field sets counter increment
// - cover word held at 0x6c/0x6d
// - cover datagrams share the output link
// - counter and currents readable 0x79-0x7b
// - low cover write starts cover datagram
// - cover length 19:13, capped at 64
// - every datagram sent msb first
// - cover reply stored at 0x6e/0x6f
package mdso_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] MDSO_IDX_CONFIG = 8'h04;
    localparam logic [7:0] MDSO_IDX_COVER_LO = 8'h6c;
    localparam logic [7:0] MDSO_IDX_COVER_HI = 8'h6d;
    localparam logic [7:0] MDSO_IDX_REPLY_LO = 8'h6e;
    localparam logic [7:0] MDSO_IDX_REPLY_HI = 8'h6f;
    localparam logic [7:0] MDSO_IDX_MSTEP = 8'h79;
    localparam logic [7:0] MDSO_IDX_CUR_A = 8'h7a;
    localparam logic [7:0] MDSO_IDX_CUR_B = 8'h7b;
    localparam logic [7:0] MDSO_IDX_MOTION = 8'h7c;
    // config field positions
    localparam int MDSO_CL_LSB = 13;
    localparam int MDSO_LOW_LSB = 20;
    localparam int MDSO_HIGH_LSB = 24;
    localparam int MDSO_BLOCK_LSB = 28;
    localparam int MDSO_AUTO_BIT = 0;
    localparam int MDSO_CURLEN_LSB = 1;
    // motion register field positions
    localparam int MDSO_RES_LSB = 0;
    // reset values and limits
    localparam logic [31:0] MDSO_CONFIG_RST = 32'h0000_0001;
    localparam logic [31:0] MDSO_MOTION_RST = 32'h0000_0000;
    localparam logic [3:0] MDSO_TIME_MIN = 4'h2;
    localparam logic [6:0] MDSO_COVER_MAX = 7'h40;
    localparam logic [6:0] MDSO_CURLEN_DEF = 7'h14;
    localparam logic [8:0] MDSO_SIN_START = 9'h000;
    localparam logic [8:0] MDSO_COS_START = 9'h0f7;
    // register bus carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } mdso_bus_t;
    // link state
    typedef enum logic [1:0] {
        MDSO_IDLE = 2'b00,
        MDSO_LOW = 2'b01,
        MDSO_HIGH = 2'b10,
        MDSO_BLOCK = 2'b11
    } mdso_state_t;
endpackage : mdso_pkg

// >>> verilog/mdso_spi_out.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mdso_spi_out
    import mdso_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // register port
    input wire mdso_bus_t bus_i,
    output logic [31:0] rdata_o,
    // ramp generator steps
    input wire logic step_i,
    input wire logic dir_i,
    // driver link
    output logic driver_chip_select_n_o,
    output logic driver_serial_clock_o,
    output logic driver_serial_out_o,
    input wire logic driver_serial_in_i,
    // status
    output logic busy_o
);
    // registers
    logic [31:0] config_reg; // output_link_config
    logic [31:0] motion_reg; // resolution field
    logic [31:0] cover_lo_reg;
    logic [31:0] cover_hi_reg;
    logic [31:0] reply_lo_reg;
    logic [31:0] reply_hi_reg;
    logic [9:0] mstep_reg; // microstep_position
    logic [8:0] cur_a_reg; // phase_a_current, signed
    logic [8:0] cur_b_reg; // phase_b_current, signed
    // link engine
    mdso_state_t state_reg;
    logic [3:0] tcnt_reg; // phase cycle counter
    logic [6:0] bits_reg; // bits still to send
    logic [63:0] shift_reg; // outgoing, msb at top
    logic [63:0] rx_reg; // incoming
    logic is_cover_reg; // datagram in flight is cover
    logic cover_pend_reg;
    logic cur_pend_reg;
    logic [1:0] miso_sync_reg; // two-stage sampler
    logic [6:0] cover_len; // clamped cover length
    logic [6:0] cur_len;
    logic [3:0] low_t;
    logic [3:0] high_t;
    logic [3:0] block_t;
    logic [9:0] step_inc;
    logic [8:0] mag_a;
    logic [8:0] mag_b;

    // effective timing; zero becomes two, up to fifteen
    function automatic logic [3:0] eff_t(input logic [3:0] v);
        eff_t = (v < MDSO_TIME_MIN) ? MDSO_TIME_MIN : v;
    endfunction : eff_t

    assign low_t = eff_t(config_reg[MDSO_LOW_LSB +: 4]);
    assign high_t = eff_t(config_reg[MDSO_HIGH_LSB +: 4]);
    assign block_t = eff_t(config_reg[MDSO_BLOCK_LSB +: 4]);

    always_comb begin
        if (config_reg[MDSO_CL_LSB +: 7] > MDSO_COVER_MAX) begin
            cover_len = MDSO_COVER_MAX;
        end else if (config_reg[MDSO_CL_LSB +: 7] == 7'h00) begin
            cover_len = MDSO_COVER_MAX; // automatic: full word
        end else begin
            cover_len = config_reg[MDSO_CL_LSB +: 7];
        end
    end

    // current datagram length: 0 selects automatic
    assign cur_len = (config_reg[MDSO_CURLEN_LSB +: 7] == 7'h00) ?
        MDSO_CURLEN_DEF : config_reg[MDSO_CURLEN_LSB +: 7];

    always_comb begin
        step_inc = 10'h001 << motion_reg[MDSO_RES_LSB +: 3];
    end

    // magnitudes of the phase currents
    assign mag_a = cur_a_reg[8] ? 9'(-cur_a_reg) : cur_a_reg;
    assign mag_b = cur_b_reg[8] ? 9'(-cur_b_reg) : cur_b_reg;

    // input synchroniser for driver reply
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            miso_sync_reg <= 2'h0;
        end else if (clk_en_i) begin
            miso_sync_reg <= {miso_sync_reg[0], driver_serial_in_i};
        end
    end

    // configuration writes
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            config_reg <= MDSO_CONFIG_RST;
            motion_reg <= MDSO_MOTION_RST;
            cover_hi_reg <= 32'h0;
            cover_lo_reg <= 32'h0;
        end else if (clk_en_i && bus_i.wr) begin
            if (bus_i.addr == MDSO_IDX_CONFIG) begin
                config_reg <= bus_i.wdata;
            end
            if (bus_i.addr == MDSO_IDX_MOTION) begin
                motion_reg <= bus_i.wdata;
            end
            if (bus_i.addr == MDSO_IDX_COVER_HI) begin
                cover_hi_reg <= bus_i.wdata;
            end
            if (bus_i.addr == MDSO_IDX_COVER_LO) begin
                cover_lo_reg <= bus_i.wdata;
            end
        end
    end

    // microstep counter and phase currents
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            mstep_reg <= 10'h000;
            cur_a_reg <= MDSO_SIN_START;
            cur_b_reg <= MDSO_COS_START;
        end else if (clk_en_i && step_i) begin
            mstep_reg <= dir_i ? mstep_reg + step_inc :
                mstep_reg - step_inc;
            // simple triangle wave stands in for the wave table
            cur_a_reg <= tri_wave(dir_i ? mstep_reg + step_inc :
                mstep_reg - step_inc);
            cur_b_reg <= tri_wave(dir_i ? mstep_reg + step_inc + 10'h100 :
                mstep_reg - step_inc + 10'h100);
        end
    end

    // signed triangle of amplitude 256 over 1024 microsteps
    function automatic logic [8:0] tri_wave(input logic [9:0] p);
        logic [8:0] up;
        up = {1'b0, p[7:0]};
        if (p[8]) begin
            up = 9'h100 - {1'b0, p[7:0]};
        end
        tri_wave = p[9] ? 9'(-up) : up;
    endfunction : tri_wave

    // pending requests; a new request wins over the clear
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cover_pend_reg <= 1'b0;
            cur_pend_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (state_reg == MDSO_IDLE && cover_pend_reg) begin
                cover_pend_reg <= 1'b0;
            end
            if (bus_i.wr && bus_i.addr == MDSO_IDX_COVER_LO) begin
                cover_pend_reg <= 1'b1;
            end
            if (state_reg == MDSO_IDLE && !cover_pend_reg &&
                cur_pend_reg) begin
                cur_pend_reg <= 1'b0;
            end
            if (step_i && config_reg[MDSO_AUTO_BIT]) begin
                cur_pend_reg <= 1'b1;
            end
        end
    end

    // link engine: load, shift, block
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_reg <= MDSO_IDLE;
            tcnt_reg <= 4'h0;
            bits_reg <= 7'h00;
            shift_reg <= 64'h0;
            rx_reg <= 64'h0;
            is_cover_reg <= 1'b0;
        end else if (clk_en_i) begin
            unique case (state_reg)
                MDSO_IDLE: begin
                    tcnt_reg <= 4'h1;
                    rx_reg <= 64'h0;
                    // cover first, one at a time
                    if (cover_pend_reg) begin
                        state_reg <= MDSO_LOW;
                        is_cover_reg <= 1'b1;
                        bits_reg <= cover_len;
                        shift_reg <= {cover_hi_reg, cover_lo_reg}
                            << (MDSO_COVER_MAX - cover_len);
                    end else if (cur_pend_reg) begin
                        state_reg <= MDSO_LOW;
                        is_cover_reg <= 1'b0;
                        bits_reg <= cur_len;
                        shift_reg <= {cur_a_reg[8], mag_a,
                            cur_b_reg[8], mag_b, 44'h0}
                            << (MDSO_CURLEN_DEF - cur_len);
                    end
                end
                MDSO_LOW: begin
                    if (tcnt_reg >= low_t) begin
                        state_reg <= MDSO_HIGH;
                        tcnt_reg <= 4'h1;
                    end else begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                    end
                end
                MDSO_HIGH: begin
                    if (tcnt_reg >= high_t) begin
                        tcnt_reg <= 4'h1;
                        // sample reply late in the high phase: pin
                        // register and synchroniser delay it three cycles
                        rx_reg <= {rx_reg[62:0], miso_sync_reg[1]};
                        shift_reg <= {shift_reg[62:0], 1'b0};
                        bits_reg <= bits_reg - 7'h01;
                        state_reg <= (bits_reg == 7'h01) ?
                            MDSO_BLOCK : MDSO_LOW;
                    end else begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                    end
                end
                MDSO_BLOCK: begin
                    if (tcnt_reg >= block_t) begin
                        state_reg <= MDSO_IDLE;
                    end else begin
                        tcnt_reg <= tcnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            reply_lo_reg <= 32'h0;
            reply_hi_reg <= 32'h0;
        end else if (clk_en_i && is_cover_reg &&
            state_reg == MDSO_BLOCK && tcnt_reg == 4'h1) begin
            reply_lo_reg <= rx_reg[31:0];
            reply_hi_reg <= rx_reg[63:32];
        end
    end

    // registered pins
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            driver_chip_select_n_o <= 1'b1;
            driver_serial_clock_o <= 1'b1;
            driver_serial_out_o <= 1'b1;
            busy_o <= 1'b0;
        end else if (clk_en_i) begin
            driver_chip_select_n_o <= !(state_reg == MDSO_LOW ||
                state_reg == MDSO_HIGH);
            driver_serial_clock_o <= (state_reg != MDSO_LOW);
            driver_serial_out_o <= shift_reg[63];
            busy_o <= (state_reg != MDSO_IDLE);
        end
    end

    // read port, data one cycle later
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rdata_o <= 32'h0;
        end else if (clk_en_i) begin
            rdata_o <= 32'h0;
            if (bus_i.rd) begin
                unique case (bus_i.addr)
                    MDSO_IDX_CONFIG: rdata_o <= config_reg;
                    MDSO_IDX_MOTION: rdata_o <= motion_reg;
                    MDSO_IDX_COVER_LO: rdata_o <= cover_lo_reg;
                    MDSO_IDX_COVER_HI: rdata_o <= cover_hi_reg;
                    MDSO_IDX_REPLY_LO: rdata_o <= reply_lo_reg;
                    MDSO_IDX_REPLY_HI: rdata_o <= reply_hi_reg;
                    MDSO_IDX_MSTEP: rdata_o <= {22'h0, mstep_reg};
                    MDSO_IDX_CUR_A: rdata_o <= {{23{cur_a_reg[8]}}, cur_a_reg};
                    MDSO_IDX_CUR_B: rdata_o <= {{23{cur_b_reg[8]}}, cur_b_reg};
                    default: rdata_o <= 32'h0; // unmapped reads zero
                endcase
            end
        end
    end

    // a_cs_idle_high: select high the cycle after idle
    a_cs_idle_high: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        (clk_en_i && state_reg == MDSO_IDLE)
        |=> driver_chip_select_n_o)
        else $error("select low while idle");

    // a_sck_low_len: low phase at least two cycles
    a_sck_low_len: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        $fell(driver_serial_clock_o) && clk_en_i
        |=> !driver_serial_clock_o || !clk_en_i)
        else $error("clock low shorter than two");

    // a_block_min: no new datagram right after end
    a_block_min: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        $rose(driver_chip_select_n_o) |=> driver_chip_select_n_o)
        else $error("block time violated");

    // a_sck_in_frame: clock low only with select low
    a_sck_in_frame: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        !driver_serial_clock_o |-> !driver_chip_select_n_o)
        else $error("clock toggles outside frame");

    // a_cover_start: low cover write is pending or link busy next cycle
    a_cover_start: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        (clk_en_i && bus_i.wr && bus_i.addr == MDSO_IDX_COVER_LO)
        |=> cover_pend_reg || state_reg != MDSO_IDLE)
        else $error("cover write lost");

    // a_step_count: counter moves by the increment
    a_step_count: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        (clk_en_i && step_i && dir_i) |=>
        mstep_reg == $past(mstep_reg) + $past(step_inc))
        else $error("counter step wrong");

    // a_cur_trigger: step with auto sets pending
    a_cur_trigger: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        (clk_en_i && step_i && config_reg[MDSO_AUTO_BIT]) |=> cur_pend_reg)
        else $error("current update not queued");

    // a_len_cap: cover length never above 64
    a_len_cap: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        cover_len <= MDSO_COVER_MAX)
        else $error("cover length over 64");
endmodule : mdso_spi_out
`default_nettype wire

// >>> testbench/mdso_drv_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdso_drv_model
#(
    parameter logic [63:0] REPLY = 64'hc3a5_96f0_1e2d_4b78
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // link pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic sdo_i,
    output logic sdi_o,
    // what the driver saw
    output logic [63:0] rx_o,
    output int bits_o,
    output int frames_o,
    output int gap_o,
    output int low_o,
    output int high_o,
    output int idle_bad_o
);
    logic [63:0] pat, rx;  // reply shifter, receive shifter
    logic act = 1'b0;      // first clock rise of the frame seen
    logic tog = 1'b0;      // idle pattern, changes every cycle
    int n = 0;
    int lc = 0;
    int hc = 0;
    int gc = 0;
    initial frames_o = 0;
    // reply: line toggles every cycle outside frames, shows no stale bit
    assign sdi_o = cs_n_i ? tog : pat[63];
    // reply loads at select, moves on each clock fall
    always @(negedge sck_i or negedge cs_n_i) begin
        if (!cs_n_i && !act) begin
            pat <= REPLY;
        end else if (act) begin
            pat <= pat << 1;
        end
    end
    // take data on the master's clock rise, arm reply shifter
    // frame closes when select is released; empty frames not counted
    always @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i === 1'b1) begin
            act <= 1'b0;
            if (n != 0) begin
                rx_o <= rx;
                bits_o <= n;
                frames_o <= frames_o + 1;
            end
            rx <= '0;
            n <= 0;
        end else if (cs_n_i === 1'b0) begin
            act <= 1'b1;
            rx <= {rx[62:0], sdo_i};
            n <= n + 1;
        end
    end
    // phase, gap and idle level watch
    always @(posedge ref_clk_i) begin
        tog <= ~tog;
        if (!resetn_i) begin
            gc <= 0;
            idle_bad_o <= 0;
        end else if (cs_n_i) begin
            gc <= gc + 1;
            lc <= 0;
            hc <= 0;
            if (!sck_i) idle_bad_o <= idle_bad_o + 1;
        end else begin
            if (gc != 0) gap_o <= gc;
            gc <= 0;
            if (sck_i) begin
                hc <= hc + 1;
                lc <= 0;
                if (lc != 0) low_o <= lc;
            end else begin
                lc <= lc + 1;
                hc <= 0;
                if (hc != 0) high_o <= hc;
            end
        end
    end
endmodule : mdso_drv_model
`default_nettype wire

// >>> testbench/mdso_spi_out_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
 $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module mdso_spi_out_bench
    import mdso_pkg::*;
;
    localparam logic [63:0] REPLY = 64'hc3a5_96f0_1e2d_4b78;
    // cover table: config, high, low, bits, low time, high time
    localparam logic [31:0] T_CFG [4] = '{32'h4531_0000, 32'hfff1_0000,
        32'h0005_0000, 32'h000c_8000};
    localparam logic [31:0] T_HI [4] = '{32'h0, 32'h0, 32'h5a, 32'h89abcdef};
    localparam logic [31:0] T_LO [4] = '{32'ha5, 32'h3c, 32'h12345678,
        32'h01234567};
    localparam int T_N [4] = '{8, 8, 40, 64};
    localparam int T_LT [4] = '{3, 15, 2, 2};
    localparam int T_HT [4] = '{5, 15, 2, 2};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic step = 1'b0;
    logic dir = 1'b0;
    logic clk_en = 1'b1;
    logic sdi, cs_n, sck, sdo, busy;
    mdso_bus_t bus = '0;
    logic [31:0] rdata, v, ca, cb;
    logic [63:0] rx, ex;
    int bits, frames, gap, low_len, high_len, idle_bad;
    int err_total = 0;
    int checks_done = 0;
    mdso_spi_out dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .clk_en_i(clk_en),
        .bus_i(bus), .rdata_o(rdata), .step_i(step), .dir_i(dir),
        .driver_chip_select_n_o(cs_n), .driver_serial_clock_o(sck),
        .driver_serial_out_o(sdo), .driver_serial_in_i(sdi), .busy_o(busy));
    mdso_drv_model #(.REPLY(REPLY)) drv (.ref_clk_i(ref_clk),
        .resetn_i(resetn), .cs_n_i(cs_n), .sck_i(sck), .sdo_i(sdo),
        .sdi_o(sdi), .rx_o(rx), .bits_o(bits), .frames_o(frames),
        .gap_o(gap), .low_o(low_len), .high_o(high_len),
        .idle_bad_o(idle_bad));
    // 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        bus <= '0;
    endtask : wr
    // read data stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge ref_clk);
        bus <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic stp(input logic d);
        @(posedge ref_clk);
        step <= 1'b1;
        dir <= d;
        @(posedge ref_clk);
        step <= 1'b0;
    endtask : stp
    // wait for n frames and an idle engine, bounded; looks at falling edge
    task automatic settle(input int n);
        int k;
        k = 0;
        while ((frames < n || busy !== 1'b0) && k < 5000) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 5000) begin
            err_total++;
            $display("wrong value at %0t: link hang", $time);
        end
    endtask : settle
    function automatic logic [9:0] fmt(input logic [8:0] c);
        return {c[8], c[8] ? 9'(-c) : c};
    endfunction : fmt
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #400000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(MDSO_IDX_CONFIG, v); `CHK(v, MDSO_CONFIG_RST)
        rd(MDSO_IDX_MSTEP, v); `CHK(v, 32'h0)
        rd(MDSO_IDX_CUR_A, v); `CHK(v, 32'h0)
        rd(MDSO_IDX_CUR_B, v); `CHK(v, 32'hf7)
        rd(8'h33, v); `CHK(v, 32'h0)
        $display("reset test done");
        stp(1'b1);
        settle(1);
        rd(MDSO_IDX_MSTEP, v); `CHK(v, 32'h1)
        rd(MDSO_IDX_CUR_A, ca);
        rd(MDSO_IDX_CUR_B, cb);
        `CHK(bits, 20)
        `CHK(rx[19:0], {fmt(ca[8:0]), fmt(cb[8:0])})
        `CHK(low_len, 2)
        `CHK(high_len, 2)
        wr(MDSO_IDX_MOTION, 32'h2);
        stp(1'b1);
        settle(2);
        rd(MDSO_IDX_MSTEP, v); `CHK(v, 32'h5)
        stp(1'b0);
        settle(3);
        rd(MDSO_IDX_MSTEP, v); `CHK(v, 32'h1)
        $display("step test done");
        for (int i = 0; i < 4; i++) begin
            wr(MDSO_IDX_CONFIG, T_CFG[i]);
            rd(MDSO_IDX_CONFIG, v); `CHK(v, T_CFG[i])
            // upper half only for long words
            if (T_N[i] > 32) wr(MDSO_IDX_COVER_HI, T_HI[i]);
            wr(MDSO_IDX_COVER_LO, T_LO[i]);
            settle(4 + i);
            ex = {T_HI[i], T_LO[i]};
            if (T_N[i] < 64) ex = ex & ((64'h1 << T_N[i]) - 64'h1);
            `CHK(bits, T_N[i])
            `CHK(rx, ex)
            `CHK(low_len, T_LT[i])
            `CHK(high_len, T_HT[i])
            ex = REPLY >> (64 - T_N[i]);
            rd(MDSO_IDX_REPLY_LO, v); `CHK(v, ex[31:0])
            rd(MDSO_IDX_REPLY_HI, v); `CHK(v, ex[63:32])
            rd(MDSO_IDX_COVER_LO, v); `CHK(v, T_LO[i])
        end
        $display("cover test done");
        wr(MDSO_IDX_CONFIG, 32'h4531_0001);
        stp(1'b1);
        wr(MDSO_IDX_COVER_LO, 32'h5a);
        settle(9);
        `CHK(frames, 9)
        `CHK(bits, 8)
        `CHK(rx, 64'h5a)
        `CHK(gap >= 4, 1'b1)
        `CHK(idle_bad, 0)
        `CHK(cs_n, 1'b1)
        `CHK(sck, 1'b1)
        $display("block test done");
        // clock enable low: a write in that cycle is ignored
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(MDSO_IDX_CONFIG, 32'h0);
        clk_en <= 1'b1;
        rd(MDSO_IDX_CONFIG, v); `CHK(v, 32'h4531_0001)
        // second reset in mid-run
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(MDSO_IDX_CONFIG, v); `CHK(v, MDSO_CONFIG_RST)
        rd(MDSO_IDX_MSTEP, v); `CHK(v, 32'h0)
        `CHK(cs_n, 1'b1)
        `CHK(sck, 1'b1)
        $display("freeze and reset test done");
        give_verdict();
    end
endmodule : mdso_spi_out_bench
`default_nettype wire
